// ===== rix_pkg.sv
package rix_pkg;
  localparam int unsigned PC_W = 15;
  localparam int unsigned OP_W = 14;
  localparam int unsigned STACK_DEPTH = 16;
  // opcode encodings; the literal form carries k in bits 7:0
  localparam logic [13:0] OPC_RETURN = 14'h0008;
  localparam logic [13:0] OPC_RET_INT = 14'h0009;
  localparam logic [5:0] OPC_RET_LIT_HI = 6'h0d;
  localparam int unsigned RET_LIT_HI_LSB = 8;
  localparam int unsigned INT_EN_BIT = 7;
  localparam logic [7:0] INTCTL_RESET = 8'h00;
  localparam logic [7:0] W_RESET = 8'h00;
  localparam logic [14:0] PC_RESET = 15'h0000;
  localparam int unsigned RET_CYCLES = 2;
  typedef enum logic [1:0] {
    RIX_KIND_NONE,
    RIX_KIND_RETURN,
    RIX_KIND_RET_INT,
    RIX_KIND_RET_LIT
  } rix_kind_t;
endpackage

// ===== rix_stack_if.sv
`timescale 1ns/1ns
`default_nettype none
interface rix_stack_if;
  logic push;
  logic [rix_pkg::PC_W-1:0] push_addr;
  logic pop;
  logic [rix_pkg::PC_W-1:0] top_entry;
  modport core (output push, output push_addr, output pop, input top_entry);
  modport mem (input push, input push_addr, input pop, output top_entry);
endinterface
`default_nettype wire

// ===== rix_stack.sv
`timescale 1ns/1ns
`default_nettype none
module rix_stack #(
  parameter int unsigned DEPTH = rix_pkg::STACK_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // port to the core
  rix_stack_if.mem stk
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [rix_pkg::PC_W-1:0] mem_q [DEPTH];
  logic [PW-1:0] ptr_q;
  logic [PW-1:0] ptr_d;
  logic [rix_pkg::PC_W-1:0] top_q;
  logic [rix_pkg::PC_W-1:0] top_d;

  // pointer wraps: overflow/underflow handling lives elsewhere
  always_comb begin
    ptr_d = ptr_q;
    top_d = top_q;
    if (stk.pop) begin
      ptr_d = ptr_q - PW'(1);
      top_d = mem_q[ptr_q - PW'(1)];
    end else if (stk.push) begin
      ptr_d = ptr_q + PW'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q <= '0;
      top_q <= rix_pkg::PC_RESET;
    end else begin
      ptr_q <= ptr_d;
      top_q <= top_d;
    end
  end

  // storage has no reset, so it maps onto a plain ram
  always_ff @(posedge clk) begin
    if (stk.push && !stk.pop) begin
      mem_q[ptr_q] <= stk.push_addr;
    end
  end

  assign stk.top_entry = top_q;
endmodule
`default_nettype wire

// ===== rix_ret_exec.sv
// Function
// - return-from-interrupt pops the stack and loads the PC with the popped entry.
// - return-from-interrupt sets global interrupt enable, bit 7 of interrupt control.
// - return-from-interrupt is one word and takes exactly two cycles.
// - subroutine return pops stack into PC, two cycles, interrupt enable untouched.
// - literal return writes its 8-bit immediate into the working register.
// - literal return also pops stack into PC, two cycles, one word.
`timescale 1ns/1ns
`default_nettype none
module rix_ret_exec #(
  parameter logic [13:0] OPC_RETURN = rix_pkg::OPC_RETURN,
  parameter logic [13:0] OPC_RET_INT = rix_pkg::OPC_RET_INT,
  parameter logic [5:0] OPC_RET_LIT_HI = rix_pkg::OPC_RET_LIT_HI,
  parameter int unsigned STACK_DEPTH = rix_pkg::STACK_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // instruction from the decoder
  input wire logic instr_valid,
  input wire logic [rix_pkg::OP_W-1:0] instr_word,
  // stack push from call or interrupt entry
  input wire logic call_push,
  input wire logic [rix_pkg::PC_W-1:0] call_addr,
  // interrupt entry clears the enable
  input wire logic int_enable_clr,
  // results
  output logic busy,
  output logic pc_load,
  output logic [rix_pkg::PC_W-1:0] pc_value,
  output logic fetch_flush,
  output logic w_load,
  output logic [7:0] w_value,
  output logic [7:0] interrupt_control_reg,
  output logic global_interrupt_enable
);
  typedef enum logic {RIX_IDLE, RIX_SECOND} rix_state_t;

  rix_state_t state_q;
  rix_state_t state_d;
  rix_pkg::rix_kind_t kind_q;
  rix_pkg::rix_kind_t kind_d;
  logic [7:0] lit_q;
  logic [7:0] lit_d;
  logic busy_q;
  logic busy_d;
  logic pc_load_q;
  logic pc_load_d;
  logic [rix_pkg::PC_W-1:0] pc_q;
  logic [rix_pkg::PC_W-1:0] pc_d;
  logic flush_q;
  logic flush_d;
  logic w_load_q;
  logic w_load_d;
  logic [7:0] w_q;
  logic [7:0] w_d;
  logic [7:0] intctl_q;
  logic [7:0] intctl_d;
  rix_pkg::rix_kind_t dec_kind;
  logic finish_lit;
  logic finish_int;

  rix_stack_if stk ();

  rix_stack #(
    .DEPTH(STACK_DEPTH)
  ) u_stack (
    .clk(clk),
    .rst_n(rst_n),
    .stk(stk)
  );

  // any other opcode is left to the rest of the core
  function automatic rix_pkg::rix_kind_t decode(input logic [13:0] op);
    if (op == OPC_RET_INT) begin
      decode = rix_pkg::RIX_KIND_RET_INT;
    end else if (op == OPC_RETURN) begin
      decode = rix_pkg::RIX_KIND_RETURN;
    end else if (op[13:rix_pkg::RET_LIT_HI_LSB] == OPC_RET_LIT_HI) begin
      decode = rix_pkg::RIX_KIND_RET_LIT;
    end else begin
      decode = rix_pkg::RIX_KIND_NONE;
    end
  endfunction

  // true in the cycle that finishes a return of the wanted kind
  function automatic logic finishing(input rix_state_t st, input rix_pkg::rix_kind_t kd,
                                     input rix_pkg::rix_kind_t want);
    finishing = (st == RIX_SECOND) && (kd == want);
  endfunction

  assign dec_kind = decode(instr_word);
  assign finish_lit = finishing(state_q, kind_q, rix_pkg::RIX_KIND_RET_LIT);
  assign finish_int = finishing(state_q, kind_q, rix_pkg::RIX_KIND_RET_INT);

  // a return accepted while idle pops at once; a call push counts only when idle with no pop, otherwise it is dropped
  assign stk.pop = (state_q == RIX_IDLE) && instr_valid
                   && (dec_kind != rix_pkg::RIX_KIND_NONE);
  assign stk.push = call_push && (state_q == RIX_IDLE) && !stk.pop;
  assign stk.push_addr = call_addr;

  // sequencer: one busy cycle while the popped entry settles in the stack register
  // valid seen while busy is dropped, so the decoder must not expect it queued
  always_comb begin
    state_d = state_q;
    kind_d = kind_q;
    lit_d = lit_q;
    busy_d = 1'b0;
    unique case (state_q)
      RIX_IDLE: begin
        if (stk.pop) begin
          state_d = RIX_SECOND;
          kind_d = dec_kind;
          lit_d = instr_word[7:0];
          busy_d = 1'b1;
        end
      end
      RIX_SECOND: begin
        state_d = RIX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= RIX_IDLE;
      kind_q <= rix_pkg::RIX_KIND_NONE;
      lit_q <= 8'h00;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      kind_q <= kind_d;
      lit_q <= lit_d;
      busy_q <= busy_d;
    end
  end

  // program counter: popped entry is in the stack's output register now
  always_comb begin
    pc_load_d = 1'b0;
    pc_d = pc_q;
    flush_d = 1'b0;
    if (state_q == RIX_SECOND) begin
      pc_load_d = 1'b1;
      pc_d = stk.top_entry;
      flush_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_load_q <= 1'b0;
      pc_q <= rix_pkg::PC_RESET;
      flush_q <= 1'b0;
    end else begin
      pc_load_q <= pc_load_d;
      pc_q <= pc_d;
      flush_q <= flush_d;
    end
  end

  // working register: only the literal form writes it
  always_comb begin
    w_load_d = 1'b0;
    w_d = w_q;
    if (finish_lit) begin
      w_load_d = 1'b1;
      w_d = lit_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w_load_q <= 1'b0;
      w_q <= rix_pkg::W_RESET;
    end else begin
      w_load_q <= w_load_d;
      w_q <= w_d;
    end
  end

  // set from the return wins over a clear in the same cycle
  // so an interrupt entry in that edge waits for the next clear
  always_comb begin
    intctl_d = intctl_q;
    if (finish_int) begin
      intctl_d[rix_pkg::INT_EN_BIT] = 1'b1;
    end else if (int_enable_clr) begin
      intctl_d[rix_pkg::INT_EN_BIT] = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      intctl_q <= rix_pkg::INTCTL_RESET;
    end else begin
      intctl_q <= intctl_d;
    end
  end

  // no status flag output exists: returns cannot touch them
  assign busy = busy_q;
  assign pc_load = pc_load_q;
  assign pc_value = pc_q;
  assign fetch_flush = flush_q;
  assign w_load = w_load_q;
  assign w_value = w_q;
  assign interrupt_control_reg = intctl_q;
  assign global_interrupt_enable = intctl_q[rix_pkg::INT_EN_BIT];
endmodule
`default_nettype wire

// ===== rix_ret_exec_checker.sv
`timescale 1ns/1ns
`default_nettype none
module rix_ret_exec_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // inputs
  input wire logic instr_valid,
  input wire logic [13:0] instr_word,
  input wire logic int_enable_clr,
  // outputs
  input wire logic busy,
  input wire logic pc_load,
  input wire logic fetch_flush,
  input wire logic w_load,
  input wire logic [7:0] w_value,
  input wire logic [7:0] interrupt_control_reg,
  input wire logic global_interrupt_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic lit = instr_word[13:8] == 6'h0d;
  wire logic tk = instr_valid && !busy && (lit || instr_word == 14'h0008 || instr_word == 14'h0009);
  chk_busy_follows: assert property (tk |=> busy && !pc_load)
    else $error("busy missing after take");
  chk_load_second: assert property (tk |-> ##2 pc_load && fetch_flush && !busy)
    else $error("pc load not in second cycle");
  chk_load_cause: assert property (pc_load |-> $past(busy))
    else $error("pc load without busy cycle");
  chk_flush_pairs: assert property (fetch_flush == pc_load)
    else $error("flush apart from pc load");
  chk_lit_load: assert property (tk && lit |-> ##2 w_load && w_value == $past(instr_word[7:0], 2))
    else $error("literal not loaded");
  chk_enable_set: assert property (tk && instr_word == 14'h0009 |-> ##2 global_interrupt_enable)
    else $error("enable not set");
  chk_enable_bit: assert property (global_interrupt_enable == interrupt_control_reg[7])
    else $error("enable bit mismatch");
  chk_enable_clear: assert property (int_enable_clr && !busy |=> !global_interrupt_enable)
    else $error("enable not cleared");
  chk_plain_return: assert property (tk && instr_word == 14'h0008 && !int_enable_clr ##1 !int_enable_clr |=> !w_load && $stable(global_interrupt_enable))
    else $error("plain return disturbed state");
endmodule
bind rix_ret_exec rix_ret_exec_checker u_chk (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid),
  .instr_word(instr_word), .int_enable_clr(int_enable_clr), .busy(busy), .pc_load(pc_load),
  .fetch_flush(fetch_flush), .w_load(w_load), .w_value(w_value),
  .interrupt_control_reg(interrupt_control_reg), .global_interrupt_enable(global_interrupt_enable));
`default_nettype wire

// ===== rix_ret_exec_tb.sv
`timescale 1ns/1ns
`default_nettype none
module rix_ret_exec_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic iv = 1'b0;
  logic cp = 1'b0;
  logic ic = 1'b0;
  logic [13:0] wd = 14'h0000;
  logic [14:0] ca = 15'h0000;
  logic [14:0] pcv;
  logic bz, pl, ff, wl, en;
  logic [7:0] wv, icr;
  int errors = 0;
  int tests_run = 0;
  always #5 clk = ~clk;
  rix_ret_exec DUT (.clk(clk), .rst_n(rst_n), .instr_valid(iv), .instr_word(wd), .call_push(cp),
    .call_addr(ca), .int_enable_clr(ic), .busy(bz), .pc_load(pl), .pc_value(pcv),
    .fetch_flush(ff), .w_load(wl), .w_value(wv), .interrupt_control_reg(icr),
    .global_interrupt_enable(en));
  task automatic chk(input logic [14:0] s, input logic [14:0] e);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic report_and_stop;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic push(input logic [14:0] a);
    cp = 1'b1;
    ca = a;
    @(negedge clk);
    cp = 1'b0;
    @(negedge clk);
  endtask
  // valid and a push stay up in the busy cycle; a stray push would show at the next pop
  task automatic ret(input logic [13:0] w, input logic [14:0] pc, input logic lw, input logic e);
    iv = 1'b1;
    wd = w;
    @(negedge clk);
    cp = 1'b1;
    ca = 15'h7fff;
    chk(bz, 1'b1);
    @(negedge clk);
    cp = 1'b0;
    chk({pl, ff, bz}, 3'h6);
    chk(pcv, pc);
    chk({wl, en, icr}, {lw, e, e, 7'h00});
    if (lw) chk(wv, w[7:0]);
  endtask
  // back to back, both ends of the literal range
  task automatic t_lit;
    push(15'h0123);
    push(15'h0456);
    ret(14'h0d00, 15'h0456, 1'b1, 1'b0);
    ret(14'h0dff, 15'h0123, 1'b1, 1'b0);
    iv = 1'b0;
    @(negedge clk);
  endtask
  task automatic t_int;
    push(15'h7abc);
    ret(14'h0009, 15'h7abc, 1'b0, 1'b1);
    iv = 1'b0;
    @(negedge clk);
  endtask
  // a clear in the finishing edge of an interrupt return loses to the set
  task automatic t_set_wins;
    push(15'h0abc);
    iv = 1'b1;
    wd = 14'h0009;
    @(negedge clk);
    ic = 1'b1;
    chk(bz, 1'b1);
    @(negedge clk);
    ic = 1'b0;
    iv = 1'b0;
    chk({pl, en}, 2'h3);
    chk(pcv, 15'h0abc);
  endtask
  task automatic t_ret;
    push(15'h0001);
    ret(14'h0008, 15'h0001, 1'b0, 1'b1);
    iv = 1'b0;
    ic = 1'b1;
    @(negedge clk);
    ic = 1'b0;
    wd = 14'h0e00;
    iv = 1'b1;
    @(negedge clk);
    iv = 1'b0;
    chk({bz, en}, 2'h0);
    chk(wv, 8'hff);
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    t_lit;
    t_int;
    t_ret;
    t_set_wins;
    report_and_stop;
  end
  initial begin
    #5000;
    errors++;
    report_and_stop;
  end
endmodule
`default_nettype wire
